// ==== logic/snie_pkg.sv ====
package snie_pkg;
    localparam logic [7:0] OP_DUAL_READ = 8'h3B;
    localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;
    localparam logic [7:0] OP_STD_ID = 8'h9F;
    localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
    localparam logic [7:0] OP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE = 8'hAB;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_SECTOR_CLEAR = 8'h20;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    // bit counts at which the header ends (opcode included)
    localparam logic [5:0] HDR_OPCODE = 6'h08;
    localparam logic [5:0] HDR_ADDR = 6'h20;
    localparam logic [5:0] HDR_ADDR_DUMMY = 6'h28;
    localparam logic [5:0] RX_CNT_MAX = 6'h3F;
    localparam logic [8:0] PAGE_STEPS = 9'h100;
    localparam logic [23:0] RST_ADDR = 24'h000000;
    localparam logic [3:0] IDX_MAX = 4'hF;
    localparam int TIMER_W = 20;
    localparam int PW_TIMER_W = 12;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int WAKE_DELAY_PLAIN_NS = 3000;
    localparam int WAKE_DELAY_WITH_CODE_NS = 1800;
    localparam int PAGE_WRITE_DURATION_US = 1000;
    localparam int SECTOR_CLEAR_DURATION_US = 60000;
    // longest time: round down, at least one cycle
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
        SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS;
    // least times: round up
    localparam int WAKE_PLAIN_CYC = (WAKE_DELAY_PLAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CODE_CYC = (WAKE_DELAY_WITH_CODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_WRITE_CYC = PAGE_WRITE_DURATION_US * 1000 / CLK_PERIOD_NS;
    localparam int SECTOR_CLEAR_CYC = SECTOR_CLEAR_DURATION_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        FR_CMD = 3'b000,
        FR_HDR = 3'b001,
        FR_OUT = 3'b010,
        FR_PROG_IN = 3'b011,
        FR_DONE = 3'b100,
        FR_IGNORE = 3'b101
    } snie_frame_t;

    typedef enum logic [1:0] {
        BZ_IDLE = 2'b00,
        BZ_PROG = 2'b01,
        BZ_ERASE = 2'b10
    } snie_busy_t;

    typedef enum logic [1:0] {
        PW_ON = 2'b00,
        PW_ENTER = 2'b01,
        PW_SLEEP = 2'b10,
        PW_WAKE = 2'b11
    } snie_pwr_t;
endpackage

// ==== logic/snie_engine.sv ====
// Functional notes
// RULE1 - dual read 3BH: address, one dummy byte, then data two bits per clock
// RULE2 - dual read starts anywhere, address steps by one after each byte
// RULE3 - 90H id read: address bit zero picks manufacturer first or device first
// RULE4 - 9FH returns manufacturer, memory type, capacity on falling edges
// RULE5 - 9FH not decoded while program or erase runs
// RULE6 - chip select high ends any id read, back to standby
// RULE7 - 4BH: four dummy bytes then fixed 64-bit value on falling edges
// RULE8 - B9H executes only if select rises after eighth bit; sleep after delay
// RULE9 - asleep only ABH is recognised, everything else ignored
// RULE10 - after reset the device is awake, never asleep
// RULE11 - bare ABH wakes the device after the plain wake delay
// RULE12 - ABH plus three dummy bytes repeats device code until select rises
// RULE13 - host keeps select high for the coded wake delay afterwards
// RULE14 - ABH ignored while write in progress
// RULE15 - page program needs write enable latch, address and data bytes
// RULE16 - program data wraps within the same page
// RULE17 - more than 256 bytes: only the last 256 are kept
// RULE18 - fewer than 256 bytes: other bytes of the page untouched
// RULE19 - program runs only if select rises on a byte boundary, then timed
// RULE20 - busy flag high during timed cycle; latch cleared before completion
// RULE21 - program into a protected page is refused
// RULE22 - sector erase: latch set, select after address, timed, protection
// RULE23 - 06H sets the write enable latch
// RULE24 - status read allowed any time while awake, also when busy
// RULE25 - dual output: even bits on the even line, odd on the odd line
// RULE26 - unknown opcode ignored, lines high impedance until select rises
module snie_engine
    import snie_pkg::*;
#(
    parameter int PAGE_WRITE_CYCLES = PAGE_WRITE_CYC,
    parameter int SECTOR_CLEAR_CYCLES = SECTOR_CLEAR_CYC,
    parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] MEM_TYPE_CODE = 8'h40, // arbitrary value
    parameter logic [7:0] CAPACITY_CODE = 8'h13, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h12, // arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF // arbitrary value
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic chip_sel_n_in,
    input wire logic serial_clk_in,
    input wire logic dual_line_even_in,
    output logic dual_line_even_out,
    output logic dual_line_even_oe_out,
    output logic dual_line_odd_out,
    output logic dual_line_odd_oe_out,
    input wire logic protect_size_bit2_in,
    input wire logic protect_size_bit1_in,
    input wire logic protect_size_bit0_in,
    output logic write_enable_latch_out,
    output logic write_in_progress_flag_out,
    output logic deep_sleep_state_out,
    output logic [23:0] mem_addr_out,
    input wire logic [7:0] mem_rdata_in,
    output logic [7:0] mem_wdata_out,
    output logic mem_write_out,
    output logic mem_sector_clear_out
);
    localparam logic [TIMER_W-1:0] PP_LAST = TIMER_W'(PAGE_WRITE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] SE_LAST = TIMER_W'(SECTOR_CLEAR_CYCLES - 1);
    localparam logic [PW_TIMER_W-1:0] DP_LAST = PW_TIMER_W'(SLEEP_ENTRY_CYC - 1);
    localparam logic [PW_TIMER_W-1:0] RES1_LAST = PW_TIMER_W'(WAKE_PLAIN_CYC - 1);
    localparam logic [PW_TIMER_W-1:0] RES2_LAST = PW_TIMER_W'(WAKE_CODE_CYC - 1);

    // pins come from the host's domain: two flops before use
    logic sclk_m_q, sclk_s_q, sclk_p_q, cs_m_q, cs_s_q, cs_p_q, si_m_q, si_s_q;
    always_ff @(posedge sys_clk_in) begin
        sclk_m_q <= serial_clk_in;
        sclk_s_q <= sclk_m_q;
        sclk_p_q <= sclk_s_q;
        cs_m_q <= chip_sel_n_in;
        cs_s_q <= cs_m_q;
        cs_p_q <= cs_s_q;
        si_m_q <= dual_line_even_in;
        si_s_q <= si_m_q;
    end

    wire sclk_rise = sclk_s_q & ~sclk_p_q & ~cs_s_q;
    wire sclk_fall = ~sclk_s_q & sclk_p_q & ~cs_s_q;
    wire cs_rise = cs_s_q & ~cs_p_q;

    snie_frame_t st_q, st_d;
    snie_busy_t busy_q;
    snie_pwr_t pw_q;
    logic [5:0] rx_cnt_q;
    logic [2:0] bitpos_q;
    logic [6:0] sh_q;
    logic [7:0] op_q;
    logic [23:0] addr_q;
    logic wel_q, wip_q, dev_first_q;

    wire [7:0] rx_byte = {sh_q, si_s_q};
    wire byte_done = sclk_rise & (bitpos_q == 3'h7);
    wire [5:0] rx_cnt_inc = (rx_cnt_q == RX_CNT_MAX) ? rx_cnt_q : rx_cnt_q + 6'h01;
    wire [7:0] op_cur = (st_q == FR_CMD) ? rx_byte : op_q;
    wire [2:0] bp = {protect_size_bit2_in, protect_size_bit1_in, protect_size_bit0_in};
    wire [7:0] status_byte = {3'h0, bp, wel_q, wip_q};

    logic [5:0] hdr_len;
    logic op_known, op_talks;
    always_comb begin
        hdr_len = HDR_OPCODE;
        op_known = 1'b1;
        op_talks = 1'b0;
        case (op_cur)
            OP_DUAL_READ, OP_UNIQUE_ID: hdr_len = HDR_ADDR_DUMMY; // RULE1 RULE7
            OP_MFR_DEV_ID, OP_WAKE, OP_PAGE_WRITE, OP_SECTOR_CLEAR: hdr_len = HDR_ADDR;
            OP_STD_ID, OP_STATUS_READ: op_talks = 1'b1;
            OP_SLEEP, OP_WRITE_ENABLE: op_talks = 1'b0;
            default: op_known = 1'b0; // RULE26
        endcase
    end

    // asleep: only the wake opcode; busy: only status read
    wire op_allowed = (pw_q == PW_SLEEP) ? (op_cur == OP_WAKE) : // RULE9
        (pw_q == PW_ON) & op_known & // RULE26
        ((busy_q == BZ_IDLE) | (op_cur == OP_STATUS_READ)); // RULE5 RULE14 RULE24

    wire hdr_end = byte_done & (st_q == FR_HDR) & (rx_cnt_inc == hdr_len);

    always_comb begin
        st_d = st_q;
        if (byte_done) begin
            case (st_q)
                FR_CMD: begin
                    if (!op_allowed) begin
                        st_d = FR_IGNORE;
                    end else if (hdr_len != HDR_OPCODE) begin
                        st_d = FR_HDR;
                    end else begin
                        st_d = op_talks ? FR_OUT : FR_DONE;
                    end
                end
                FR_HDR: begin
                    if (rx_cnt_inc == hdr_len) begin
                        if (op_q == OP_PAGE_WRITE) begin
                            st_d = FR_PROG_IN;
                        end else if (op_q == OP_SECTOR_CLEAR) begin
                            st_d = FR_DONE;
                        end else begin
                            st_d = FR_OUT;
                        end
                    end
                end
                default: st_d = st_q;
            endcase
        end
    end

    // protected top region grows with the protect code
    function automatic logic prot_hit_f(input logic [2:0] blk, input logic [2:0] code);
        case (code)
            3'h0: prot_hit_f = 1'b0;
            3'h1: prot_hit_f = (blk == 3'h7);
            3'h2: prot_hit_f = (blk >= 3'h6);
            3'h3: prot_hit_f = (blk >= 3'h4);
            default: prot_hit_f = 1'b1;
        endcase
    endfunction
    wire prot_hit = prot_hit_f(addr_q[18:16], bp);

    // execution happens only on the rising select edge; exact bit count except program (any byte boundary) and coded wake
    wire at_op_end = cs_rise & (st_q == FR_DONE) & (rx_cnt_q == HDR_OPCODE);
    wire go_sleep = at_op_end & (op_q == OP_SLEEP) & (pw_q == PW_ON); // RULE8
    wire go_wel = at_op_end & (op_q == OP_WRITE_ENABLE); // RULE23
    wire go_wake1 = cs_rise & (st_q == FR_HDR) & (op_q == OP_WAKE) &
        (rx_cnt_q == HDR_OPCODE) & (pw_q == PW_SLEEP); // RULE11
    wire go_wake2 = cs_rise & (st_q == FR_OUT) & (op_q == OP_WAKE) & (pw_q == PW_SLEEP);
    wire go_prog = cs_rise & (st_q == FR_PROG_IN) & (rx_cnt_q >= HDR_ADDR_DUMMY) &
        (bitpos_q == 3'h0) & wel_q & ~prot_hit; // RULE15 RULE19 RULE21
    wire go_erase = cs_rise & (st_q == FR_DONE) & (op_q == OP_SECTOR_CLEAR) &
        (rx_cnt_q == HDR_ADDR) & wel_q & ~prot_hit; // RULE22

    always_ff @(posedge sys_clk_in) begin
        if (srst_in | cs_s_q) begin
            st_q <= FR_CMD; // RULE6
            rx_cnt_q <= 6'h00;
            bitpos_q <= 3'h0;
            sh_q <= 7'h00;
        end else begin
            st_q <= st_d;
            if (sclk_rise) begin
                rx_cnt_q <= rx_cnt_inc;
                bitpos_q <= bitpos_q + 3'h1;
                sh_q <= rx_byte[6:0];
            end
        end
    end

    // header capture; addr stays frozen while busy since only status read decodes
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            op_q <= 8'h00;
            addr_q <= RST_ADDR;
            dev_first_q <= 1'b0;
        end else if (byte_done) begin
            if (st_q == FR_CMD) begin
                op_q <= rx_byte;
            end
            if ((st_q == FR_HDR) & (rx_cnt_q < HDR_ADDR)) begin
                addr_q <= {addr_q[15:0], rx_byte};
            end
            if (hdr_end & (op_q == OP_MFR_DEV_ID)) begin
                dev_first_q <= rx_byte[0]; // RULE3
            end
        end
    end

    // page buffer: later bytes overwrite earlier ones at the same column
    logic [7:0] pbuf [0:255];
    logic [255:0] pvalid_q;
    logic [7:0] col_q;
    logic [8:0] step_q;
    wire page_in = byte_done & (st_q == FR_PROG_IN);
    always_ff @(posedge sys_clk_in) begin
        if (page_in) begin
            pbuf[col_q] <= rx_byte; // RULE17
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pvalid_q <= '0;
            col_q <= 8'h00;
        end else if (hdr_end & (op_q == OP_PAGE_WRITE)) begin
            pvalid_q <= '0; // RULE18
            col_q <= rx_byte;
        end else if (page_in) begin
            pvalid_q[col_q] <= 1'b1;
            col_q <= col_q + 8'h01; // RULE16
        end
    end

    // self-timed cycle; latch cleared at the start, flag cleared at the end
    logic [TIMER_W-1:0] tmr_q;
    logic mem_we_q, clr_q;
    logic [7:0] wdata_q;
    wire tmr_done = ((busy_q == BZ_PROG) & (tmr_q == PP_LAST)) |
        ((busy_q == BZ_ERASE) & (tmr_q == SE_LAST));
    wire step_on = (busy_q == BZ_PROG) & (step_q < PAGE_STEPS);
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            busy_q <= BZ_IDLE;
            tmr_q <= '0;
            step_q <= 9'h000;
            wip_q <= 1'b0;
            wel_q <= 1'b0;
            mem_we_q <= 1'b0;
            wdata_q <= 8'h00;
            clr_q <= 1'b0;
        end else begin
            mem_we_q <= step_on & pvalid_q[step_q[7:0]]; // RULE18
            wdata_q <= pbuf[step_q[7:0]];
            clr_q <= go_erase; // RULE22
            if (go_wel) begin
                wel_q <= 1'b1; // RULE23
            end else if (go_prog | go_erase) begin
                wel_q <= 1'b0; // RULE20
            end
            case (busy_q)
                BZ_IDLE: begin
                    tmr_q <= '0;
                    step_q <= 9'h000;
                    if (go_prog | go_erase) begin
                        busy_q <= go_prog ? BZ_PROG : BZ_ERASE;
                        wip_q <= 1'b1; // RULE20
                    end
                end
                BZ_PROG, BZ_ERASE: begin
                    tmr_q <= tmr_q + TIMER_W'(1);
                    if (step_on) begin
                        step_q <= step_q + 9'h001;
                    end
                    if (tmr_done) begin
                        busy_q <= BZ_IDLE;
                        wip_q <= 1'b0; // RULE20
                    end
                end
                default: busy_q <= BZ_IDLE;
            endcase
        end
    end

    // power state: always comes up awake
    logic [PW_TIMER_W-1:0] pw_tmr_q, pw_last_q;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pw_q <= PW_ON; // RULE10
            pw_tmr_q <= '0;
            pw_last_q <= '0;
        end else begin
            pw_tmr_q <= pw_tmr_q + PW_TIMER_W'(1);
            case (pw_q)
                PW_ON: begin
                    pw_tmr_q <= '0;
                    if (go_sleep) begin
                        pw_q <= PW_ENTER; // RULE8
                    end
                end
                PW_ENTER: begin
                    if (pw_tmr_q == DP_LAST) begin
                        pw_q <= PW_SLEEP;
                    end
                end
                PW_SLEEP: begin
                    pw_tmr_q <= '0;
                    if (go_wake1 | go_wake2) begin
                        pw_q <= PW_WAKE; // RULE11 RULE12
                        pw_last_q <= go_wake1 ? RES1_LAST : RES2_LAST;
                    end
                end
                PW_WAKE: begin
                    if (pw_tmr_q == pw_last_q) begin
                        pw_q <= PW_ON;
                    end
                end
                default: pw_q <= PW_ON;
            endcase
        end
    end

    // serial output; each byte is fetched at the falling edge that sends its first bits
    logic [7:0] rem_q, io_byte;
    logic [2:0] left_q;
    logic [3:0] idx_q;
    logic [23:0] rd_addr_q;
    wire dual = (op_q == OP_DUAL_READ);
    wire load_byte = sclk_fall & (st_q == FR_OUT) & (left_q == 3'h0);
    wire shift_bit = sclk_fall & (st_q == FR_OUT) & (left_q != 3'h0);
    wire [7:0] uid_byte = (idx_q < 4'h8) ? UNIQUE_ID[{3'h7 - idx_q[2:0], 3'h0} +: 8] : 8'h00;
    always_comb begin
        case (op_q)
            OP_DUAL_READ: io_byte = mem_rdata_in; // RULE1
            OP_MFR_DEV_ID: io_byte = (idx_q[0] ^ dev_first_q) ? DEVICE_CODE : MFR_CODE; // RULE3
            OP_STD_ID: io_byte = (idx_q == 4'h0) ? MFR_CODE : (idx_q == 4'h1) ? MEM_TYPE_CODE :
                (idx_q == 4'h2) ? CAPACITY_CODE : 8'h00; // RULE4
            OP_UNIQUE_ID: io_byte = uid_byte; // RULE7
            OP_WAKE: io_byte = DEVICE_CODE; // RULE12
            OP_STATUS_READ: io_byte = status_byte; // RULE24
            default: io_byte = 8'h00;
        endcase
    end
    always_ff @(posedge sys_clk_in) begin
        if (srst_in | cs_s_q) begin
            dual_line_odd_oe_out <= 1'b0; // RULE6 RULE26
            dual_line_even_oe_out <= 1'b0;
            dual_line_odd_out <= 1'b0;
            dual_line_even_out <= 1'b0;
            rem_q <= 8'h00;
            left_q <= 3'h0;
            idx_q <= 4'h0;
        end else if (load_byte) begin
            dual_line_odd_oe_out <= 1'b1;
            dual_line_even_oe_out <= dual;
            dual_line_odd_out <= io_byte[7];
            dual_line_even_out <= dual & io_byte[6]; // RULE25
            rem_q <= dual ? {io_byte[5:0], 2'b00} : {io_byte[6:0], 1'b0};
            left_q <= dual ? 3'h3 : 3'h7;
            idx_q <= (idx_q == IDX_MAX) ? idx_q : idx_q + 4'h1;
        end else if (shift_bit) begin
            dual_line_odd_out <= rem_q[7];
            dual_line_even_out <= dual & rem_q[6]; // RULE25
            rem_q <= dual ? {rem_q[5:0], 2'b00} : {rem_q[6:0], 1'b0};
            left_q <= left_q - 3'h1;
        end
    end

    // read address: loaded at end of header, stepped as each byte is taken
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rd_addr_q <= RST_ADDR;
        end else if (hdr_end & dual) begin
            rd_addr_q <= addr_q;
        end else if (load_byte & dual) begin
            rd_addr_q <= rd_addr_q + 24'h000001; // RULE2
        end
    end

    // one-cycle lag on step keeps address aligned with the registered strobe
    logic [23:0] wr_addr_q;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            wr_addr_q <= RST_ADDR;
        end else if (go_erase) begin
            wr_addr_q <= {addr_q[23:12], 12'h000};
        end else if (step_on) begin
            wr_addr_q <= {addr_q[23:8], step_q[7:0]};
        end
    end

    assign mem_addr_out = (busy_q == BZ_IDLE) & ~clr_q ? rd_addr_q : wr_addr_q;
    assign mem_wdata_out = wdata_q;
    assign mem_write_out = mem_we_q;
    assign mem_sector_clear_out = clr_q;
    assign write_enable_latch_out = wel_q;
    assign write_in_progress_flag_out = wip_q;
    assign deep_sleep_state_out = (pw_q == PW_SLEEP) | (pw_q == PW_WAKE);

    a_wip_held: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE20
        $rose(wip_q) |-> !wel_q ##1 (wip_q && !wel_q)[*8])
        else $error("busy flag or latch wrong after cycle start");
    a_prog_needs_wel: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE15
        (busy_q == BZ_IDLE) ##1 (busy_q == BZ_PROG) |-> $past(wel_q) && !$past(prot_hit))
        else $error("program started without latch or into protected page");
    a_erase_pulse: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE22
        go_erase |=> clr_q && (busy_q == BZ_ERASE) && (mem_addr_out[11:0] == 12'h000))
        else $error("sector clear not started correctly");
    a_sleep_entry: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE8
        $rose(pw_q == PW_SLEEP) |-> $past(pw_q) == PW_ENTER)
        else $error("sleep entered without entry delay");
    a_sleep_only_wake: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE9
        (pw_q == PW_SLEEP) && byte_done && (st_q == FR_CMD) && (rx_byte != OP_WAKE)
        |=> st_q == FR_IGNORE)
        else $error("opcode decoded while asleep");
    a_reset_awake: assert property (@(posedge sys_clk_in) // RULE10
        srst_in |=> !deep_sleep_state_out)
        else $error("device not awake after reset");
    a_std_id_busy: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE5
        (busy_q != BZ_IDLE) && byte_done && (st_q == FR_CMD) && (rx_byte == OP_STD_ID)
        |=> (st_q == FR_IGNORE) && (busy_q != BZ_IDLE))
        else $error("identification decoded during busy cycle");
    a_cs_release: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE6
        cs_s_q |=> !dual_line_odd_oe_out && !dual_line_even_oe_out && (st_q == FR_CMD))
        else $error("lines driven after select released");
    a_ignore_hiz: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE26
        (st_q == FR_IGNORE) |-> !dual_line_odd_oe_out && !dual_line_even_oe_out)
        else $error("lines driven for ignored opcode");
endmodule

// ==== sim/snie_host.sv ====
module snie_host (
    input wire logic sys_clk_in,
    input wire logic so_in,
    input wire logic even_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic si_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        si_out = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic sel();
        wt(1);
        cs_n_out <= 1'b0;
        wt(4);
    endtask
    // released line shows the inverse, never the last value
    task automatic desel();
        wt(4);
        cs_n_out <= 1'b1;
        si_out <= ~si_out;
        wt(6);
    endtask
    // mode 0: set after fall, sampled on rise, half period 4 clocks
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_out <= tx[i];
            wt(4);
            sclk_out <= 1'b1;
            rx[i] = so_in;
            wt(4);
            sclk_out <= 1'b0;
        end
    endtask
    task automatic xd(output logic [7:0] rx);
        for (int i = 3; i >= 0; i--) begin
            wt(4);
            sclk_out <= 1'b1;
            rx[2*i+1] = so_in;
            rx[2*i] = even_in;
            wt(4);
            sclk_out <= 1'b0;
        end
    endtask
endmodule

// ==== sim/snie_engine_test.sv ====
module snie_engine_test import snie_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [2:0] bp = 3'h0;
    logic tog = 1'b0;
    logic oe_seen = 1'b0;
    logic cs_n, sclk, si, ev_o, ev_oe, od_o, od_oe, write_enable_latch, write_in_progress_flag, slp, mw, msc;
    logic [23:0] maddr, clr_a;
    logic [7:0] mwd, r;
    logic [31:0] wq[$];
    int n_errors = 0;
    int cmp_count = 0;
    wire logic ev_line = ev_oe ? ev_o : si;
    snie_host i_snie_host (.sys_clk_in(sys_clk_in), .so_in(od_oe ? od_o : tog),
        .even_in(ev_oe ? ev_o : tog), .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si));
    snie_engine #(.PAGE_WRITE_CYCLES(1000), .SECTOR_CLEAR_CYCLES(50)) i_snie_engine (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .chip_sel_n_in(cs_n),
        .serial_clk_in(sclk), .dual_line_even_in(ev_line), .dual_line_even_out(ev_o),
        .dual_line_even_oe_out(ev_oe), .dual_line_odd_out(od_o), .dual_line_odd_oe_out(od_oe),
        .protect_size_bit2_in(bp[2]), .protect_size_bit1_in(bp[1]), .protect_size_bit0_in(bp[0]),
        .write_enable_latch_out(write_enable_latch), .write_in_progress_flag_out(write_in_progress_flag),
        .deep_sleep_state_out(slp), .mem_addr_out(maddr), .mem_rdata_in(maddr[7:0] ^ 8'hA5),
        .mem_wdata_out(mwd), .mem_write_out(mw), .mem_sector_clear_out(msc));
    always #50 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        tog <= ~tog;
        if (mw) wq.push_back({maddr, mwd});
        if (msc) clr_a <= maddr;
        if (ev_oe | od_oe) oe_seen <= 1'b1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic op(input logic [7:0] c);
        i_snie_host.sel();
        i_snie_host.xb(c, r);
        i_snie_host.desel();
    endtask
    // frame of opcode plus bytes whose answer must stay high impedance
    task automatic quiet(input logic [7:0] c, input int n);
        oe_seen = 1'b0;
        i_snie_host.sel();
        i_snie_host.xb(c, r);
        repeat (n) i_snie_host.xb(8'h00, r);
        i_snie_host.desel();
    endtask
    task automatic tx4(input logic [7:0] c, input logic [23:0] a);
        i_snie_host.sel();
        i_snie_host.xb(c, r);
        for (int i = 2; i >= 0; i--) i_snie_host.xb(a[8*i+:8], r);
    endtask
    task automatic idle_wip(input int n);
        for (int k = 0; k < n && write_in_progress_flag; k++) i_snie_host.wt(1);
    endtask
    task automatic t_ids();
        logic [63:0] uid;
        uid = 64'h0123456789ABCDEF;
        chk({write_enable_latch, write_in_progress_flag, slp, ev_oe, od_oe}, 0);
        i_snie_host.sel();
        i_snie_host.xb(OP_STD_ID, r);
        i_snie_host.xb(8'h00, r);
        chk(r, 8'h5A);
        i_snie_host.xb(8'h00, r);
        chk(r, 8'h40);
        i_snie_host.xb(8'h00, r);
        chk(r, 8'h13);
        i_snie_host.desel();
        chk(od_oe, 0);
        for (int a = 0; a < 2; a++) begin
            tx4(OP_MFR_DEV_ID, 24'(a));
            i_snie_host.xb(8'h00, r);
            chk(r, a ? 8'h12 : 8'h5A);
            i_snie_host.xb(8'h00, r);
            chk(r, a ? 8'h5A : 8'h12);
            i_snie_host.desel();
        end
        i_snie_host.sel();
        i_snie_host.xb(OP_UNIQUE_ID, r);
        repeat (4) i_snie_host.xb(8'h00, r);
        for (int i = 7; i >= 0; i--) begin
            i_snie_host.xb(8'h00, r);
            chk(r, uid[8*i+:8]);
        end
        i_snie_host.desel();
        tx4(OP_DUAL_READ, 24'h0001FE);
        i_snie_host.xb(8'h00, r);
        for (int k = 0; k < 3; k++) begin
            i_snie_host.xd(r);
            chk(r, 8'(8'hFE + k) ^ 8'hA5);
        end
        i_snie_host.desel();
        quiet(8'hFF, 1);
        chk(oe_seen, 0);
        $display("ids and reads done");
    endtask
    task automatic t_prog();
        op(OP_WRITE_ENABLE);
        chk(write_enable_latch, 1);
        tx4(OP_PAGE_WRITE, 24'h0001FE);
        for (int i = 1; i <= 3; i++) i_snie_host.xb(8'(8'h11 * i), r);
        i_snie_host.desel();
        chk({write_in_progress_flag, write_enable_latch}, 2'b10);
        quiet(OP_STD_ID, 1);
        chk(oe_seen, 0);
        quiet(OP_WAKE, 4);
        chk(oe_seen, 0);
        i_snie_host.sel();
        i_snie_host.xb(OP_STATUS_READ, r);
        i_snie_host.xb(8'h00, r);
        chk(r, 8'h01);
        i_snie_host.desel();
        idle_wip(1000);
        chk(write_in_progress_flag, 0);
        chk(wq.size(), 3);
        foreach (wq[i])
            chk(wq[i][7:0], wq[i][31:8] == 24'h0001FE ? 8'h11 :
                wq[i][31:8] == 24'h0001FF ? 8'h22 : wq[i][31:8] == 24'h000100 ? 8'h33 : 8'h00);
        wq.delete();
        bp <= 3'h2;
        op(OP_WRITE_ENABLE);
        tx4(OP_PAGE_WRITE, 24'h060000);
        i_snie_host.xb(8'h55, r);
        i_snie_host.desel();
        i_snie_host.wt(300);
        chk({write_in_progress_flag, 31'(wq.size())}, 0);
        $display("program done");
    endtask
    // latch still set here: protected erase first, then real one, then no latch
    task automatic t_erase_sleep();
        bp <= 3'h4;
        tx4(OP_SECTOR_CLEAR, 24'h001234);
        i_snie_host.desel();
        chk({write_in_progress_flag, write_enable_latch}, 2'b01);
        bp <= 3'h0;
        tx4(OP_SECTOR_CLEAR, 24'h001234);
        i_snie_host.desel();
        chk({write_in_progress_flag, write_enable_latch, clr_a}, {2'b10, 24'h001000});
        idle_wip(100);
        chk(write_in_progress_flag, 0);
        tx4(OP_SECTOR_CLEAR, 24'h002000);
        i_snie_host.desel();
        chk(write_in_progress_flag, 0);
        op(OP_SLEEP);
        i_snie_host.wt(30);
        chk(slp, 1);
        quiet(OP_STATUS_READ, 1);
        chk(oe_seen, 0);
        op(OP_WAKE);
        i_snie_host.wt(30);
        chk(slp, 0);
        op(OP_SLEEP);
        i_snie_host.wt(30);
        i_snie_host.sel();
        repeat (4) i_snie_host.xb(OP_WAKE, r);
        for (int k = 0; k < 2; k++) begin
            i_snie_host.xb(8'h00, r);
            chk(r, 8'h12);
        end
        i_snie_host.desel();
        chk(slp, 1);
        i_snie_host.wt(18);
        chk(slp, 0);
        $display("erase and sleep done");
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        i_snie_host.wt(5);
        t_ids();
        t_prog();
        t_erase_sleep();
        end_sim();
    end
    initial begin
        repeat (30000) @(posedge sys_clk_in);
        n_errors++;
        end_sim();
    end
endmodule
